// File: src/subclock_interval_timer.sv
// Subclock interval timer with AXI4-Lite register slave
`include "interval_timer_cfg.svh"

// Behaviour
// - 15-bit counter counts every subclock tick, wraps
// - Counts subclock only, ignoring system clock select
// - Eight intervals, 2^8 through 2^15 periods
// - Three-bit select picks carry-out counter bit
// - Interval reached sets overflow flag
// - Enable gates overflow flag onto interrupt request
// - Request goes to interrupt number 28
// - Outputs stabilisation wait and watchdog clock
// - Clear circuit zeroes whole counter
module subclock_interval_timer #(
   parameter int CNT_W = `CNT_WIDTH
) (
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // Subclock tick from the oscillator domain
   input  wire logic              subclockTick,
   // AXI4-Lite write address and data
   input  wire logic [3:0]        s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output      logic              s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output      logic              s_axi_wready,
   // AXI4-Lite write response
   output      logic [1:0]        s_axi_bresp,
   output      logic              s_axi_bvalid,
   input  wire logic              s_axi_bready,
   // AXI4-Lite read
   input  wire logic [3:0]        s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output      logic              s_axi_arready,
   output      logic [31:0]       s_axi_rdata,
   output      logic [1:0]        s_axi_rresp,
   output      logic              s_axi_rvalid,
   input  wire logic              s_axi_rready,
   // Interrupt and watchdog side
   output      logic              intervalIrq,
   output      logic [5:0]        intervalIrqNumber,
   output      logic              irq,
   output      logic              watchdogTick,
   output      logic              watchdogSourceSelect,
   output      logic              stabilizeDone
);

   logic                rstSync1;
   logic                rstSync2;
   logic                tickSync1;
   logic                tickSync2;
   logic                tickPrev;
   logic [CNT_W-1:0]    counter;
   logic [CNT_W-1:0]    next_counter;
   logic [2:0]          intervalSelect;
   logic                intervalIrqEnable;
   logic                intervalOverflowFlag;
   logic                clearCounter;
   logic [2:0]          status;
   logic [2:0]          mask;
   logic [3:0]          awAddr;
   logic [31:0]         wData;
   logic [3:0]          wStrb;
   logic                awHeld;
   logic                wHeld;
   interval_timer_pkg::wr_state_t wrState;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstSync1 <= 1'b0;
         rstSync2 <= 1'b0;
      end else begin
         rstSync1 <= 1'b1;
         rstSync2 <= rstSync1;
      end
   end

   wire sysRst_n = rstSync2;

   // Subclock tick synchronised then edge detected
   always_ff @(posedge clk or negedge sysRst_n) begin
      if (!sysRst_n) begin
         tickSync1 <= 1'b0;
         tickSync2 <= 1'b0;
         tickPrev  <= 1'b0;
      end else begin
         tickSync1 <= subclockTick;
         tickSync2 <= tickSync1;
         tickPrev  <= tickSync2;
      end
   end

   wire countEn = tickSync2 & ~tickPrev;

   // Counter and interval detection
   assign next_counter = counter + 1'b1;
   wire [CNT_W-1:0] carryBits = counter & ~next_counter;
   wire [3:0]       tapIndex  = 4'(`MIN_TAP) + {1'b0, intervalSelect};
   wire             intervalHit = countEn & carryBits[tapIndex];

   always_ff @(posedge clk or negedge sysRst_n) begin
      if (!sysRst_n) begin
         counter <= '0;
      end else if (clearCounter) begin
         counter <= '0;
      end else if (countEn) begin
         counter <= next_counter;
      end
   end

   // Watchdog clock and stabilisation wait
   always_ff @(posedge clk or negedge sysRst_n) begin
      if (!sysRst_n) begin
         watchdogTick  <= 1'b0;
         stabilizeDone <= 1'b0;
      end else begin
         watchdogTick <= countEn & carryBits[CNT_W-1];
         if (clearCounter) begin
            stabilizeDone <= 1'b0;
         end else if (countEn & carryBits[CNT_W-1]) begin
            stabilizeDone <= 1'b1;
         end
      end
   end

   // Write decode
   wire wrFire   = awHeld & wHeld & (wrState == interval_timer_pkg::WR_IDLE);
   wire wrCtl    = wrFire & (awAddr == `OFF_CONTROL) & wStrb[0];
   wire wrMask   = wrFire & (awAddr == `OFF_MASK) & wStrb[0];
   wire wrMapped = (awAddr == `OFF_CONTROL) | (awAddr == `OFF_STATUS) |
                   (awAddr == `OFF_MASK) | (awAddr == `OFF_COUNT);
   wire flagClear = wrCtl & ~wData[`CTL_OF_BIT];

   assign clearCounter = wrCtl & wData[`CTL_CLR_BIT];

   // Control register
   always_ff @(posedge clk or negedge sysRst_n) begin
      if (!sysRst_n) begin
         intervalSelect       <= 3'(`CTL_RESET);
         intervalIrqEnable    <= 1'b0;
         watchdogSourceSelect <= 1'b0;
      end else if (wrCtl) begin
         intervalSelect       <= wData[`CTL_SEL_LSB +: 3];
         intervalIrqEnable    <= wData[`CTL_IE_BIT];
         watchdogSourceSelect <= wData[`CTL_WATCHDOG_SOURCE_SELECT_BIT];
      end
   end

   // Overflow flag, set wins over clear
   always_ff @(posedge clk or negedge sysRst_n) begin
      if (!sysRst_n) begin
         intervalOverflowFlag <= 1'b0;
      end else if (intervalHit) begin
         intervalOverflowFlag <= 1'b1;
      end else if (flagClear) begin
         intervalOverflowFlag <= 1'b0;
      end
   end

   assign intervalIrq       = intervalOverflowFlag & intervalIrqEnable;
   assign intervalIrqNumber = `IRQ_NUMBER;

   // Sticky status: interval, stabilisation, watchdog tick
   wire [2:0] events   = {watchdogTick, countEn & carryBits[CNT_W-1], intervalHit};
   wire       rdFire   = s_axi_arvalid & s_axi_arready;
   wire       rdStatus = rdFire & (s_axi_araddr == `OFF_STATUS);

   always_ff @(posedge clk or negedge sysRst_n) begin
      if (!sysRst_n) begin
         status <= '0;
         mask   <= '0;
      end else begin
         status <= events | (rdStatus ? 3'h0 : status);
         if (wrMask) begin
            mask <= wData[2:0];
         end
      end
   end

   assign irq = |(status & mask);

   // Write channel capture
   assign s_axi_awready = ~awHeld & (wrState == interval_timer_pkg::WR_IDLE);
   assign s_axi_wready  = ~wHeld & (wrState == interval_timer_pkg::WR_IDLE);

   always_ff @(posedge clk or negedge sysRst_n) begin
      if (!sysRst_n) begin
         awHeld  <= 1'b0;
         wHeld   <= 1'b0;
         awAddr  <= '0;
         wData   <= '0;
         wStrb   <= '0;
         wrState <= interval_timer_pkg::WR_IDLE;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            awHeld <= 1'b1;
            awAddr <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wHeld <= 1'b1;
            wData <= s_axi_wdata;
            wStrb <= s_axi_wstrb;
         end
         case (wrState)
            interval_timer_pkg::WR_IDLE: begin
               if (wrFire) begin
                  awHeld       <= 1'b0;
                  wHeld        <= 1'b0;
                  s_axi_bvalid <= 1'b1;
                  s_axi_bresp  <= wrMapped ? `RESP_OKAY : `RESP_SLVERR;
                  wrState      <= interval_timer_pkg::WR_RESP;
               end
            end
            interval_timer_pkg::WR_RESP: begin
               if (s_axi_bready) begin
                  s_axi_bvalid <= 1'b0;
                  wrState      <= interval_timer_pkg::WR_IDLE;
               end
            end
            default: wrState <= interval_timer_pkg::WR_IDLE;
         endcase
      end
   end

   // Read channel
   wire [31:0] ctlRead = {25'h0, 1'b0, watchdogSourceSelect, intervalOverflowFlag,
                          intervalIrqEnable, intervalSelect};
   wire        rdMapped = (s_axi_araddr == `OFF_CONTROL) | (s_axi_araddr == `OFF_STATUS) |
                          (s_axi_araddr == `OFF_MASK) | (s_axi_araddr == `OFF_COUNT);
   wire [31:0] rdMux = (s_axi_araddr == `OFF_CONTROL) ? ctlRead :
                       (s_axi_araddr == `OFF_STATUS)  ? {29'h0, status} :
                       (s_axi_araddr == `OFF_MASK)    ? {29'h0, mask} :
                       (s_axi_araddr == `OFF_COUNT)   ? {17'h0, counter} : 32'h0;

   assign s_axi_arready = ~s_axi_rvalid;

   always_ff @(posedge clk or negedge sysRst_n) begin
      if (!sysRst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= '0;
         s_axi_rresp  <= `RESP_OKAY;
      end else if (rdFire) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rdMux;
         s_axi_rresp  <= rdMapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end

endmodule

// File: src/interval_timer_cfg.svh
// Register offsets, field positions, reset values and interrupt number of the interval timer
`ifndef INTERVAL_TIMER_CFG_SVH
`define INTERVAL_TIMER_CFG_SVH
`define CNT_WIDTH       15
`define SEL_WIDTH       3
`define MIN_TAP         7
`define IRQ_NUMBER      6'h1c
`define OFF_CONTROL     4'h0
`define OFF_STATUS      4'h4
`define OFF_MASK        4'h8
`define OFF_COUNT       4'hc
`define CTL_SEL_LSB     0
`define CTL_IE_BIT      3
`define CTL_OF_BIT      4
`define CTL_WATCHDOG_SOURCE_SELECT_BIT    5
`define CTL_CLR_BIT     6
`define CTL_RESET       32'h0000_0000
`define CTL_WMASK       32'h0000_003f
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2
`endif

// File: src/interval_timer_pkg.sv
// Types shared by the interval timer
package interval_timer_pkg;
   typedef enum logic [1:0] {
      WR_IDLE,
      WR_RESP
   } wr_state_t;
endpackage

// File: test/interval_timer_assertions.sv
// Port assertions for the subclock interval timer
module interval_timer_checker (
   input wire logic        clk, rst_n, s_axi_awvalid, s_axi_awready, s_axi_wvalid,
   input wire logic        s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready,
   input wire logic        s_axi_rvalid, intervalIrq, watchdogTick,
   input wire logic [3:0]  s_axi_awaddr, s_axi_wstrb,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [5:0]  intervalIrqNumber
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   wire wrTake = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire wrCtl  = wrTake && s_axi_awaddr == 4'h0 && s_axi_wstrb[0];
   a_irq_number: assert property (intervalIrqNumber == 6'h1c)
      else $error("interrupt number wrong");
   a_wd_pulse: assert property (watchdogTick |=> !watchdogTick)
      else $error("watchdog tick too long");
   a_ie_gate: assert property (wrCtl && !s_axi_wdata[3] |=> ##2 !intervalIrq)
      else $error("request while disabled");
   a_of_keep: assert property (wrCtl && s_axi_wdata[4:3] == 2'b11 && intervalIrq
      |=> intervalIrq [*3]) else $error("flag lost on write of one");
   a_b_answer: assert property (wrTake |=> ##1 s_axi_bvalid)
      else $error("no write response");
   a_r_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read response");
   a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready)
      else $error("address taken while response pending");
   a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while data pending");
endmodule

bind subclock_interval_timer interval_timer_checker u_chk (.clk(clk), .rst_n(rst_n),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
   .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .intervalIrq(intervalIrq),
   .watchdogTick(watchdogTick), .s_axi_awaddr(s_axi_awaddr), .s_axi_wstrb(s_axi_wstrb),
   .s_axi_wdata(s_axi_wdata), .intervalIrqNumber(intervalIrqNumber));

// File: test/irq_ctrl_model.sv
// Interrupt controller and watchdog clock model
module irq_ctrl_model (
   input  wire logic       clk,
   input  wire logic       intervalIrq,
   input  wire logic [5:0] intervalIrqNumber,
   input  wire logic       watchdogTick,
   input  wire logic       watchdogSourceSelect,
   output      logic [5:0] takenNumber,
   output      int         wdCount
);
   timeunit 1ns;
   timeprecision 1ps;
   initial takenNumber = 6'h0;
   initial wdCount = 0;
   always @(posedge clk) begin
      if (intervalIrq) takenNumber <= intervalIrqNumber;
      if (watchdogTick && !watchdogSourceSelect) wdCount <= wdCount + 1;
   end
endmodule

// File: test/test_subclock_interval_timer.sv
// Self-checking bench for the subclock interval timer
module test_subclock_interval_timer;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst_n = 0, tick = 0, awv = 0, wv = 0, bRdy = 0, arv = 0, rRdy = 0;
   logic awr, wr, bv, arr, rv, iIrq, irq, wdt, wds;
   logic [3:0] awa = 0, ara = 0;
   logic [31:0] wd = 0, rd, v, seed = 32'hc750;
   logic [1:0] br, rr, resp;
   logic [5:0] num, taken;
   int wdCnt, error_cnt = 0, check_count = 0, modelCnt = 0;
   always #20 clk = ~clk;
   subclock_interval_timer dut_u (.clk(clk), .rst_n(rst_n), .subclockTick(tick),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bRdy), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv),
      .s_axi_rready(rRdy), .intervalIrq(iIrq), .intervalIrqNumber(num), .irq(irq),
      .watchdogTick(wdt), .watchdogSourceSelect(wds), .stabilizeDone());
   irq_ctrl_model part_u (.clk(clk), .intervalIrq(iIrq), .intervalIrqNumber(num),
      .watchdogTick(wdt), .watchdogSourceSelect(wds), .takenNumber(taken), .wdCount(wdCnt));
   task automatic complete_run;
      $display("checks %0d errors %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] t;
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      return t ^ (t << 5);
   endfunction
   task automatic ticks(input int k);
      repeat (k) begin
         tick <= 1;
         repeat (2) @(posedge clk);
         tick <= 0;
         repeat (2) @(posedge clk);
      end
      modelCnt += k;
      repeat (8) @(posedge clk);
   endtask
   task automatic wr32(input logic [3:0] a, input logic [31:0] d);
      int n;
      logic awDone, wDone, bDone;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      bRdy <= 1;
      bDone = 0;
      for (n = 0; n < 64 && !bDone; n++) begin
         @(negedge clk);
         awDone = awv && awr;
         wDone = wv && wr;
         bDone = bv && bRdy;
         if (bDone) resp = br;
         @(posedge clk);
         if (awDone) awv <= 0;
         if (wDone) wv <= 0;
      end
      bRdy <= 0;
      if (!bDone) error_cnt++;
      if (!bDone) complete_run();
   endtask
   task automatic rd32(input logic [3:0] a);
      int n;
      logic arDone, rDone;
      @(posedge clk);
      ara <= a;
      arv <= 1;
      rRdy <= 1;
      rDone = 0;
      for (n = 0; n < 64 && !rDone; n++) begin
         @(negedge clk);
         arDone = arv && arr;
         rDone = rv && rRdy;
         if (rDone) v = rd;
         if (rDone) resp = rr;
         @(posedge clk);
         if (arDone) arv <= 0;
      end
      rRdy <= 0;
      if (!rDone) error_cnt++;
      if (!rDone) complete_run();
   endtask
   initial begin
      repeat (6) @(posedge clk);
      rst_n <= 1;
      repeat (3) @(posedge clk);
      rd32(4'h8);
      chk(v, 32'h0);
      wr32(4'h0, 32'h40);
      modelCnt = 0;
      rd32(4'hc);
      chk(v, 32'h0);
      seed = xs(seed);
      ticks(int'(seed[5:0]) + 1);
      rd32(4'hc);
      chk(v, 32'(modelCnt));
      wr32(4'h8, 32'h1);
      for (int n = 0; n < 8; n++) begin
         wr32(4'h0, 32'h48 | 32'(n));
         rd32(4'h0);
         chk(v, 32'h8 | 32'(n));
         if (n < 6) begin
            ticks((1 << (n + 8)) - 1);
            chk(iIrq, 1'b0);
            ticks(1);
            chk(iIrq, 1'b1);
            chk(irq, 1'b1);
            chk(taken, 6'h1c);
            rd32(4'h4);
            chk(v, 32'h1);
            chk(irq, 1'b0);
            wr32(4'h0, 32'h18 | 32'(n));
            chk(iIrq, 1'b1);
            wr32(4'h0, 32'h10 | 32'(n));
            chk(iIrq, 1'b0);
            rd32(4'h0);
            chk(v, 32'h10 | 32'(n));
            wr32(4'h0, 32'h8 | 32'(n));
            chk(iIrq, 1'b0);
         end
      end
      wr32(4'h8, 32'h0);
      wr32(4'h0, 32'h48);
      ticks(256);
      chk({irq, iIrq}, 2'b01);
      wr32(4'h0, 32'h20);
      rd32(4'h0);
      chk(32'(wds), 32'h1);
      chk(v, 32'h20);
      seed = xs(seed);
      wr32(4'h6, seed);
      chk(32'(resp), 32'h2);
      rd32(4'h6);
      chk(32'(resp), 32'h2);
      chk(v, 32'h0);
      complete_run();
   end
endmodule
